// ---- inc/delay_tap_pkg.sv ----
package delay_tap_pkg;

	// Tap code geometry.
	localparam int TAP_W = 8;
	localparam int TAP_STEPS = 256;
	localparam int TAP_MSB = 7;
	localparam logic [TAP_W-1:0] TAP_RESET = 8'h00;
	localparam logic [TAP_W-1:0] SHIFT_RESET = 8'h00;

	// Clock rate of the control domain.
	localparam int SYS_CLK_PERIOD_NS = 8;

	// Timing figures in ns and the cycle counts they allow (longest times round down).
	localparam int PARALLEL_SETTLE_NS = 40;
	localparam int ENABLE_SETTLE_NS = 45;
	localparam int READBACK_VALID_NS = 20;
	localparam int SHIFT_RELEASE_NS = 20;
	localparam int PARALLEL_SETTLE_CYC = PARALLEL_SETTLE_NS / SYS_CLK_PERIOD_NS;
	localparam int ENABLE_SETTLE_CYC = ENABLE_SETTLE_NS / SYS_CLK_PERIOD_NS;
	localparam int READBACK_VALID_CYC = READBACK_VALID_NS / SYS_CLK_PERIOD_NS;
	localparam int SHIFT_RELEASE_CYC = SHIFT_RELEASE_NS / SYS_CLK_PERIOD_NS;

	// One delay step equals one control clock period.
	localparam int STEP_NS = SYS_CLK_PERIOD_NS;

	// Source of the next tap code.
	typedef enum logic [1:0] {
		LOAD_NONE,
		LOAD_FOLLOW,
		LOAD_LATCH,
		LOAD_SERIAL
	} load_sel_t;

	function automatic logic fell(input logic now_level, input logic prev_level);
		fell = prev_level & ~now_level;
	endfunction : fell

endpackage : delay_tap_pkg

// ---- design/level_sync.sv ----
`timescale 1ns/1ps

module level_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter bit INVERT = 1'b0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;
	wire logic [WIDTH-1:0] meta_pol;

	// The optional inversion sits between the stages so the output stays a flop.
	assign meta_pol = INVERT ? ~meta : meta;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			meta <= INVERT ? ~RESET_VAL : RESET_VAL;
			sync_o <= RESET_VAL;
		end else begin
			meta <= async_i;
			sync_o <= meta_pol;
		end
	end

endmodule : level_sync

// ---- design/delay_tap_program_interface.sv ----
`timescale 1ns/1ps

// Contract
// - An 8-bit unsigned code selects one of 256 taps; each step adds one delay.
// - Mode high and enable high: program bits drive the tap code directly.
// - Mode high, enable pulsed: program bits are captured on the enable fall.
// - Mode low: serial input shifts in on shift clock rise while enable high, MSB first.
// - In serial mode the enable fall moves the shift word into the tap code.
// - While shifting, the previous shift word leaves on the serial output, MSB first.
// - Within 20 ns of enable rise the serial output is driven with bit 7, before any shift edge.
// - The first shift edge presents bit 6; six more edges present the rest.
// - A transparent change reaches the tap code within 40 ns.
// - A latched or serial load reaches the tap code within 45 ns of enable fall.
// - Serial output is driven only while enable is high, released within 20 ns.
module delay_tap_program_interface
	import delay_tap_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic shift_clock_i,
	input wire logic interface_select_i,
	input wire logic address_enable_i,
	input wire logic [TAP_W-1:0] program_bits_i,
	input wire logic serial_in_i,
	input wire logic signal_in_i,
	output logic serial_out_o,
	output logic serial_out_oe_n_o,
	output logic [TAP_W-1:0] tap_code_o,
	output logic tap_update_o,
	output logic delayed_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: the serial shift register on the controller's shift clock.

	// Enable and mode are sampled directly here: the controller launches them
	// with setup and hold to the shift clock, and a synchroniser would cost the
	// first shift edge.
	logic [TAP_W-1:0] shift_word;
	wire logic shift_en;

	assign shift_en = address_enable_i & ~interface_select_i;

	// Reset reaches this flop asynchronously as well; the shift clock stands
	// still while the controller holds reset, so its release cannot race an edge.
	always_ff @(posedge shift_clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shift_word <= SHIFT_RESET;
		end else if (shift_en) begin
			shift_word <= {shift_word[TAP_MSB-1:0], serial_in_i};
		end
	end

	// The serial output is bit 7 of the shift word itself, so it is valid as soon as the
	// output enable drives it, within two control cycles of the enable rise, and steps to bit 6 on the first edge.
	assign serial_out_o = shift_word[TAP_MSB];

	////////////////////////////////////////////////////////////////////////////////
	// Crossings into the control domain.

	logic mode_s;
	logic ae_s;
	logic [TAP_W-1:0] pb_s;
	logic [TAP_W-1:0] shift_word_s;
	logic sig_s;

	level_sync #(
		.WIDTH(2),
		.RESET_VAL(2'h0),
		.INVERT(1'b0)
	) u_ctrl_sync (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i({interface_select_i, address_enable_i}),
		.sync_o({mode_s, ae_s})
	);

	level_sync #(
		.WIDTH(TAP_W),
		.RESET_VAL(TAP_RESET),
		.INVERT(1'b0)
	) u_pb_sync (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i(program_bits_i),
		.sync_o(pb_s)
	);

	// The shift word is frozen while the enable is low, so by the time the
	// enable fall has been synchronised this word copy is settled.
	level_sync #(
		.WIDTH(TAP_W),
		.RESET_VAL(SHIFT_RESET),
		.INVERT(1'b0)
	) u_word_sync (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i(shift_word),
		.sync_o(shift_word_s)
	);

	// Output enable straight from the second stage keeps the release inside two
	// control cycles; it follows the enable in both modes.
	level_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b1),
		.INVERT(1'b1)
	) u_oe_sync (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i(address_enable_i),
		.sync_o(serial_out_oe_n_o)
	);

	// The signal input is synchronised like any other pin; this adds two cycles
	// to the inherent delay in exchange for a chain that never goes metastable.
	level_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b0),
		.INVERT(1'b0)
	) u_sig_sync (
		.clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.async_i(signal_in_i),
		.sync_o(sig_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Tap code selection.

	logic ae_prev;
	logic [TAP_W-1:0] pb_prev;
	logic [TAP_W-1:0] pb_held;
	logic [TAP_W-1:0] next_tap;
	load_sel_t load_sel;
	wire logic ae_fell;
	wire logic pb_stable;
	wire logic follow_ok;

	assign ae_fell = fell(ae_s, ae_prev);
	// Two equal samples in a row filter the skew between the synchronised bits.
	assign pb_stable = (pb_s == pb_prev);
	assign follow_ok = mode_s & ae_s & pb_stable;

	// An enable fall outranks the follow path, because the pins may already be
	// moving towards the next code when the captured value is due.
	always_comb begin
		if (ae_fell && mode_s) begin
			load_sel = LOAD_LATCH;
		end else if (ae_fell) begin
			load_sel = LOAD_SERIAL;
		end else if (follow_ok) begin
			load_sel = LOAD_FOLLOW;
		end else begin
			load_sel = LOAD_NONE;
		end
	end

	always_comb begin
		case (load_sel)
			LOAD_FOLLOW: begin
				next_tap = pb_s;
			end
			LOAD_LATCH: begin
				next_tap = pb_held;
			end
			LOAD_SERIAL: begin
				next_tap = shift_word_s;
			end
			default: begin
				next_tap = tap_code_o;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ae_prev <= 1'b0;
			pb_prev <= TAP_RESET;
			pb_held <= TAP_RESET;
			tap_code_o <= TAP_RESET;
			tap_update_o <= 1'b0;
		end else begin
			ae_prev <= ae_s;
			pb_prev <= pb_s;
			// Last sample taken with the enable still high lies inside the
			// data setup window before the fall.
			if (ae_s) begin
				pb_held <= pb_s;
			end
			tap_code_o <= next_tap;
			// The pulse marks real changes only, so reloading the same code stays quiet.
			tap_update_o <= (next_tap != tap_code_o);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Delay chain and tap multiplexer.

	// Each element holds the input for one control period; a change of code
	// while the input toggles can emit spurious edges, so the input must idle.
	// Limitation: the step is tied to the control clock, so a finer step needs
	// a faster clock rather than a wider code.
	logic [TAP_STEPS-1:0] chain;
	wire logic tap_bit;

	assign tap_bit = chain[tap_code_o];

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chain <= '0;
			delayed_o <= 1'b0;
		end else begin
			chain <= {chain[TAP_STEPS-2:0], sig_s};
			delayed_o <= tap_bit;
		end
	end

endmodule : delay_tap_program_interface

// ---- verification/delay_tap_monitor.sv ----
`timescale 1ns/1ps
module delay_tap_monitor
	import delay_tap_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic interface_select_i,
	input wire logic address_enable_i,
	input wire logic [TAP_W-1:0] program_bits_i,
	input wire logic signal_in_i,
	input wire logic serial_out_oe_n_o,
	input wire logic [TAP_W-1:0] tap_code_o,
	input wire logic tap_update_o,
	input wire logic delayed_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	chk_tap_hold: assert property (
		(!interface_select_i && address_enable_i) [*4] |-> $stable(tap_code_o)) else $error("tap moved");
	chk_update_marks: assert property (
		$changed(tap_code_o) |-> tap_update_o) else $error("no update pulse");
	chk_update_true: assert property (
		tap_update_o |-> tap_code_o != $past(tap_code_o)) else $error("false update");
	chk_pins_follow: assert property (
		(interface_select_i && address_enable_i && $stable(program_bits_i)) [*5]
		|-> tap_code_o == program_bits_i) else $error("pins not followed");
	chk_oe_drive: assert property (
		address_enable_i [*3] |-> !serial_out_oe_n_o) else $error("output not driven");
	chk_oe_release: assert property (
		!address_enable_i [*3] |-> serial_out_oe_n_o) else $error("output not released");
	chk_latch_load: assert property (
		$fell(address_enable_i) && interface_select_i
		|-> ##5 tap_code_o == $past(program_bits_i, 6)) else $error("latch load wrong");
	chk_zero_delay: assert property (
		(tap_code_o == 8'h00 && $stable(signal_in_i)) [*8] |-> delayed_o == signal_in_i)
		else $error("delayed output wrong");
endmodule : delay_tap_monitor

bind delay_tap_program_interface delay_tap_monitor delay_tap_monitor_inst (.sys_clk_i, .nrst_i,
	.interface_select_i, .address_enable_i, .program_bits_i, .signal_in_i, .serial_out_oe_n_o,
	.tap_code_o, .tap_update_o, .delayed_o);

// ---- verification/delay_tap_host.sv ----
`timescale 1ns/1ps
module delay_tap_host (
	input wire logic serial_out_i,
	output logic shift_clock_o = 1'b0,
	output logic serial_in_o = 1'b0
);
	// The shift clock stands low between frames; 15 ns halves give setup and hold margin.
	task automatic send(input logic [7:0] word, output logic [7:0] seen);
		for (int i = 7; i >= 0; i--) begin
			serial_in_o = word[i];
			#15 seen[i] = serial_out_i;
			shift_clock_o = 1'b1;
			#15 shift_clock_o = 1'b0;
		end
		serial_in_o = ~word[0];
	endtask : send
endmodule : delay_tap_host

// ---- verification/delay_tap_program_interface_tb.sv ----
`timescale 1ns/1ps
module delay_tap_program_interface_tb;
	import delay_tap_pkg::*;
	logic sys_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic interface_select_i = 1'b1;
	logic address_enable_i = 1'b0;
	logic [TAP_W-1:0] program_bits_i = 8'h00;
	logic signal_in_i = 1'b0;
	logic shift_clock_i, serial_in_i, serial_out_o, serial_out_oe_n_o, tap_update_o, delayed_o;
	logic [TAP_W-1:0] tap_code_o;
	logic [7:0] rd;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #4 sys_clk_i = ~sys_clk_i;
	delay_tap_program_interface delay_tap_program_interface_inst (.sys_clk_i, .nrst_i,
		.shift_clock_i, .interface_select_i, .address_enable_i, .program_bits_i, .serial_in_i,
		.signal_in_i, .serial_out_o, .serial_out_oe_n_o, .tap_code_o, .tap_update_o, .delayed_o);
	// A released output reads as the inverse, so a late drive shows up as a wrong bit.
	delay_tap_host delay_tap_host_inst (
		.serial_out_i(serial_out_oe_n_o ? ~serial_out_o : serial_out_o),
		.shift_clock_o(shift_clock_i),
		.serial_in_o(serial_in_i));
	////////////////////////////////////////
	task automatic wait_clk(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : wait_clk
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		if (errors == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	task automatic t_transparent();
		logic [7:0] codes [3] = '{8'h01, 8'h80, 8'hff};
		address_enable_i <= 1'b1;
		signal_in_i <= 1'b1;
		wait_clk(12);
		check(delayed_o, 1'b1);
		signal_in_i <= 1'b0;
		wait_clk(TAP_STEPS + 4);
		foreach (codes[i]) begin
			program_bits_i <= codes[i];
			wait_clk(5);
			check(tap_code_o, codes[i]);
		end
	endtask : t_transparent
	task automatic t_step();
		program_bits_i <= 8'h10;
		wait_clk(5);
		check(tap_code_o, 8'h10);
		signal_in_i <= 1'b1;
		wait_clk(20);
		check(delayed_o, 1'b0);
		wait_clk(1);
		check(delayed_o, 1'b1);
		signal_in_i <= 1'b0;
		wait_clk(TAP_STEPS + 4);
	endtask : t_step
	task automatic t_latched();
		program_bits_i <= 8'h5a;
		wait_clk(6);
		address_enable_i <= 1'b0;
		wait_clk(1);
		program_bits_i <= 8'ha5;
		wait_clk(8);
		check(tap_code_o, 8'h5a);
	endtask : t_latched
	task automatic t_serial();
		interface_select_i <= 1'b0;
		wait_clk(4);
		address_enable_i <= 1'b1;
		wait_clk(4);
		check(serial_out_oe_n_o, 1'b0);
		delay_tap_host_inst.send(8'h3c, rd);
		check(rd, SHIFT_RESET);
		check(tap_code_o, 8'h5a);
		wait_clk(2);
		address_enable_i <= 1'b0;
		wait_clk(5);
		check(serial_out_oe_n_o, 1'b1);
		check(tap_code_o, 8'h3c);
		address_enable_i <= 1'b1;
		wait_clk(4);
		delay_tap_host_inst.send(8'hc3, rd);
		check(rd, 8'h3c);
		delay_tap_host_inst.send(rd, rd);
		check(rd, 8'hc3);
		wait_clk(2);
		address_enable_i <= 1'b0;
		wait_clk(5);
		check(tap_code_o, 8'h3c);
	endtask : t_serial
	// A hang in any scenario still reaches the single verdict below.
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		wait_clk(12);
		nrst_i <= 1'b1;
		wait_clk(2);
		t_transparent();
		t_step();
		t_latched();
		t_serial();
		final_report();
	end
endmodule : delay_tap_program_interface_tb
